//--- rtl/msg_cfg.svh
// constants of the serial slave front end: offsets, fields, codes, timing
// assumes a 200 MHz system clock
`ifndef MSG_CFG_SVH
`define MSG_CFG_SVH
`define MSG_CLK_HZ 200000000
`define MSG_BAUD_0 9600
`define MSG_BAUD_1 19200
`define MSG_BAUD_2 57600
`define MSG_BAUD_3 115200
`define MSG_CHAR_BITS 11
`define MSG_T15_X2 3
`define MSG_T35_X2 7
`define MSG_ADDR_MAX 8'hf7
`define MSG_FN_READ 8'h03
`define MSG_FN_WRITE 8'h06
`define MSG_FN_DIAG 8'h08
`define MSG_FN_PASS 8'h41
`define MSG_EXC_NONE 8'h00
`define MSG_EXC_FUNC 8'h01
`define MSG_EXC_DATA 8'h03
`define MSG_EXC_LINK 8'h0b
`define MSG_LEN_RTU 8'h08
`define MSG_LEN_ASCII 8'h07
`define MSG_CH_COLON 7'h3a
`define MSG_CH_CR 7'h0d
`define MSG_CH_LF 7'h0a
`define MSG_CRC_INIT 16'hffff
`define MSG_CRC_POLY 16'ha001
`define MSG_OFFLINE_MS 16'h00c8
`define MSG_MS_NS 1000000
`define MSG_REG_STATUS 8'h00
`define MSG_REG_TIMER 8'h04
`define MSG_REG_TX 8'h08
`define MSG_REG_LINK 8'h0c
`endif

//--- rtl/msg_front_end.sv
// serial slave front end: switch config, character receiver, rtu/ascii framing,
// frame checks, function filter, downstream off-line timer, tx character path.
// assumes synchronous switch and line inputs and a classic wishbone master.
// Operation
// RULE1: address switches form node address, first msb
// RULE2: address 0 or 248..255 disables device
// RULE3: switch change aborts transaction in progress
// RULE4: even parity over 8 or 7 bits
// RULE5: bad parity suppresses the response; an ascii closing lf with bad parity is still answered
// RULE6: no parity: slot is stop, 0 suppresses; a 0 there on the ascii closing lf is ignored
// RULE7: framing switch off rtu, on ascii
// RULE8: two switches pick one of four rates
// RULE9: only functions 03 06 08 41 accepted
// RULE10: function 41 passes through downstream
// RULE11: off-line timer loads 200 ms at reset
// RULE12: downstream timeout means no response
// RULE13: after timeout, error until link cleared
// RULE14: timer writable and readable, volatile
// RULE15: master starts transactions and bounds waits
// RULE16: master waits at least off-line time
// RULE17: rtu char: start, 8 data, parity, stop
// RULE18: ascii char: start, 7 data, parity, stop
// RULE19: rtu 3.5 char idle, 1.5 gap invalidates
// RULE20: ascii colon start, cr lf end, hex pairs
// RULE21: crc or lrc mismatch discards frame silently
// RULE22: error answer carries exception 01, 03, 0b
// RULE23: baud switches map to rates ascending
// RULE24: mid-bit sampling, start bit rechecked
`include "msg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_front_end import msg_pkg::*; #(
  parameter int CLK_HZ = `MSG_CLK_HZ,
  parameter int CYC_PER_MS = `MSG_CLK_HZ / (1000000000 / `MSG_MS_NS)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] node_address_switches_i,
  input wire logic parity_select_switch_i,
  input wire logic framing_mode_switch_i,
  input wire logic baud_select_high_switch_i,
  input wire logic baud_select_low_switch_i,
  input wire logic line_rxd_i,
  output logic line_txd_o,
  output logic line_drive_en_o,
  output logic ds_req_o,
  input wire logic ds_ans_i
);
  localparam logic [5:0] T15 = 6'((`MSG_CHAR_BITS * `MSG_T15_X2 + 1) / 2);
  localparam logic [5:0] T35 = 6'((`MSG_CHAR_BITS * `MSG_T35_X2 + 1) / 2);
  localparam logic [17:0] MS_LAST = 18'(CYC_PER_MS - 1);

  // ----------------------------------------
  // switch configuration
  // ----------------------------------------
  logic [11:0] cfg, sw;
  logic cfg_chg, nopar, ascii, enabled;
  logic [7:0] node;
  msg_cnt_t bit_len;
  logic [3:0] nd;
  assign sw = {node_address_switches_i, parity_select_switch_i, framing_mode_switch_i,
               baud_select_high_switch_i, baud_select_low_switch_i};
  // RULE3: any switch change aborts
  assign cfg_chg = sw != cfg;
  // RULE1: first switch is the msb
  assign node = cfg[11:4];
  assign nopar = cfg[3];
  // RULE7: framing mode select
  assign ascii = cfg[2];
  // RULE2: reserved addresses disable
  assign enabled = (node != 8'h00) && (node <= `MSG_ADDR_MAX);
  assign nd = ascii ? 4'h7 : 4'h8;
  // RULE8 RULE23: rate select, ascending
  always_comb begin
    case (cfg[1:0])
      2'b00: bit_len = 16'(CLK_HZ / `MSG_BAUD_0);
      2'b01: bit_len = 16'(CLK_HZ / `MSG_BAUD_1);
      2'b10: bit_len = 16'(CLK_HZ / `MSG_BAUD_2);
      default: bit_len = 16'(CLK_HZ / `MSG_BAUD_3);
    endcase
  end
  // a reset config of all zeros differs from most straps, so the first cycle after reset aborts harmlessly
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) cfg <= 12'h000;
    else cfg <= sw;
  end

  // ----------------------------------------
  // character receiver
  // ----------------------------------------
  msg_rx_e rs, next_rs;
  msg_cnt_t rc, next_rc, gc, next_gc;
  logic [3:0] rb, next_rb;
  logic [7:0] sh, next_sh;
  logic perr, next_perr, glate, next_glate, gidle, next_gidle, char_v, char_err;
  logic [5:0] gb, next_gb;
  always_comb begin
    next_rs = rs;
    next_rc = rc;
    next_rb = rb;
    next_sh = sh;
    next_perr = perr;
    next_glate = glate;
    next_gidle = gidle;
    next_gc = gc;
    next_gb = gb;
    char_v = 1'b0;
    char_err = 1'b0;
    case (rs)
      R_IDLE: if (!line_rxd_i) begin
        next_rs = R_START;
        next_rc = bit_len >> 1;
        next_glate = gb >= T15;
        // gb clears during the char, so idle is latched at its start
        next_gidle = gb == T35;
      end
      // RULE24: recheck start at mid-bit
      R_START: if (rc != 16'h0000) next_rc = rc - 16'h0001;
        else if (line_rxd_i) next_rs = R_IDLE;
        else begin
          next_rs = R_BITS;
          next_rc = bit_len - 16'h0001;
          next_rb = 4'h0;
          next_sh = 8'h00;
        end
      R_BITS: if (rc != 16'h0000) next_rc = rc - 16'h0001;
        else begin
          next_rc = bit_len - 16'h0001;
          if (rb < nd) begin
            // RULE17: lsb first data bits
            next_sh[rb[2:0]] = line_rxd_i;
            next_rb = rb + 4'h1;
          end else begin
            // RULE4: even parity, or RULE6: second stop
            next_perr = line_rxd_i != (nopar ? 1'b1 : ^sh);
            next_rs = R_STOP;
          end
        end
      R_STOP: if (rc != 16'h0000) next_rc = rc - 16'h0001;
        else begin
          char_v = 1'b1;
          char_err = perr | !line_rxd_i;
          next_rs = R_IDLE;
        end
      default: next_rs = R_IDLE;
    endcase
    // RULE19: silence counted in bit times
    if (rs != R_IDLE) begin
      next_gc = 16'h0000;
      next_gb = 6'h00;
    end else if (gc >= bit_len - 16'h0001) begin
      next_gc = 16'h0000;
      if (gb != T35) next_gb = gb + 6'h01;
    end else next_gc = gc + 16'h0001;
    if (cfg_chg) next_rs = R_IDLE;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rs <= R_IDLE;
      rc <= 16'h0000;
      rb <= 4'h0;
      sh <= 8'h00;
      perr <= 1'b0;
      glate <= 1'b0;
      gidle <= 1'b0;
      gc <= 16'h0000;
      gb <= T35;
    end else begin
      rs <= next_rs;
      rc <= next_rc;
      rb <= next_rb;
      sh <= next_sh;
      perr <= next_perr;
      glate <= next_glate;
      gidle <= next_gidle;
      gc <= next_gc;
      gb <= next_gb;
    end
  end

  // ----------------------------------------
  // framing and frame checks
  // ----------------------------------------
  logic f_act, next_f_act, f_bad, next_f_bad, nph, next_nph, crs, next_crs;
  logic [7:0] f_cnt, next_f_cnt, lrc, next_lrc, f_adr, next_f_adr, f_fn, next_f_fn;
  logic [15:0] crc, next_crc;
  logic [3:0] nib, next_nib, hexn;
  logic hexv, add_v, eval, chk_ok, accept;
  logic [7:0] add_d;
  logic [6:0] ch;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ `MSG_CRC_POLY) : (r >> 1);
    return r;
  endfunction
  assign ch = sh[6:0];
  assign hexv = (ch >= 7'h30 && ch <= 7'h39) || (ch >= 7'h41 && ch <= 7'h46);
  assign hexn = (ch <= 7'h39) ? ch[3:0] : ch[3:0] + 4'h9;
  always_comb begin
    next_f_act = f_act;
    next_f_bad = f_bad;
    next_nph = nph;
    next_crs = crs;
    next_f_cnt = f_cnt;
    next_lrc = lrc;
    next_crc = crc;
    next_f_adr = f_adr;
    next_f_fn = f_fn;
    next_nib = nib;
    add_v = 1'b0;
    add_d = sh;
    eval = 1'b0;
    if (!ascii) begin
      if (char_v && !f_act && gidle) begin
        next_f_act = 1'b1;
        next_f_bad = char_err;
        next_f_cnt = 8'h00;
        next_crc = `MSG_CRC_INIT;
        add_v = 1'b1;
      end else if (char_v && f_act) begin
        // RULE19: late byte spoils the frame; RULE5: so does a bad char
        next_f_bad = f_bad | glate | char_err;
        add_v = 1'b1;
      end
      if (f_act && gb == T35) begin
        eval = 1'b1;
        next_f_act = 1'b0;
      end
    end else if (char_v) begin
      // RULE20: colon opens, cr lf closes, hex pairs high first
      if (ch == `MSG_CH_COLON) begin
        next_f_act = 1'b1;
        next_f_bad = char_err;
        next_f_cnt = 8'h00;
        next_lrc = 8'h00;
        next_nph = 1'b0;
        next_crs = 1'b0;
      end else if (f_act) begin
        next_f_bad = f_bad | char_err;
        if (crs) begin
          next_f_act = 1'b0;
          eval = ch == `MSG_CH_LF;
        end else if (ch == `MSG_CH_CR) begin
          next_crs = 1'b1;
          next_f_bad = f_bad | char_err | nph;
        end else if (hexv) begin
          next_nph = !nph;
          next_nib = hexn;
          add_v = nph;
          add_d = {nib, hexn};
        end else next_f_bad = 1'b1;
      end
    end
    if (add_v) begin
      if (next_f_cnt != 8'hff) next_f_cnt = next_f_cnt + 8'h01;
      next_crc = crc_step(next_crc, add_d);
      next_lrc = next_lrc + add_d;
      if (next_f_cnt == 8'h01) next_f_adr = add_d;
      if (next_f_cnt == 8'h02) next_f_fn = add_d;
    end
    if (cfg_chg) begin
      next_f_act = 1'b0;
      eval = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      f_act <= 1'b0;
      f_bad <= 1'b0;
      nph <= 1'b0;
      crs <= 1'b0;
      f_cnt <= 8'h00;
      lrc <= 8'h00;
      crc <= `MSG_CRC_INIT;
      f_adr <= 8'h00;
      f_fn <= 8'h00;
      nib <= 4'h0;
    end else begin
      f_act <= next_f_act;
      f_bad <= next_f_bad;
      nph <= next_nph;
      crs <= next_crs;
      f_cnt <= next_f_cnt;
      lrc <= next_lrc;
      crc <= next_crc;
      f_adr <= next_f_adr;
      f_fn <= next_f_fn;
      nib <= next_nib;
    end
  end
  // RULE21: residue zero over whole frame
  assign chk_ok = ascii ? (lrc == 8'h00 && f_cnt >= 8'h03) : (crc == 16'h0000 && f_cnt >= 8'h04);
  assign accept = eval && !f_bad && chk_ok && enabled && (f_adr == node || f_adr == 8'h00);

  // ----------------------------------------
  // decision, downstream link, off-line timer
  // ----------------------------------------
  logic rdy, next_rdy, link_err, next_link_err, ds_wait, next_ds_wait, r_sup, next_r_sup;
  logic r_bc, next_r_bc, next_ds_req, sup, len_bad, timeout, wr;
  logic [7:0] r_fn, next_r_fn, r_exc, next_r_exc, exc;
  logic [15:0] tmr, next_tmr, ms_left, next_ms_left;
  logic [17:0] ms_cnt, next_ms_cnt;
  // RULE9: supported function filter
  assign sup = f_fn inside {`MSG_FN_READ, `MSG_FN_WRITE, `MSG_FN_DIAG, `MSG_FN_PASS};
  assign len_bad = (f_fn == `MSG_FN_READ || f_fn == `MSG_FN_WRITE) &&
                   f_cnt != (ascii ? `MSG_LEN_ASCII : `MSG_LEN_RTU);
  // RULE22: exception selection, RULE13: link error first
  assign exc = link_err ? `MSG_EXC_LINK : !sup ? `MSG_EXC_FUNC : len_bad ? `MSG_EXC_DATA : `MSG_EXC_NONE;
  assign timeout = ds_wait && !ds_ans_i && ms_cnt == MS_LAST && ms_left <= 16'h0001;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  always_comb begin
    next_rdy = rdy;
    next_link_err = link_err;
    next_ds_wait = ds_wait;
    next_r_sup = r_sup;
    next_r_bc = r_bc;
    next_r_fn = r_fn;
    next_r_exc = r_exc;
    next_tmr = tmr;
    next_ms_left = ms_left;
    next_ms_cnt = ms_cnt;
    next_ds_req = 1'b0;
    // clears first so that a same-cycle set wins
    if (wr && wb_adr_i == `MSG_REG_STATUS && wb_sel_i[0] && wb_dat_i[0]) next_rdy = 1'b0;
    if (wr && wb_adr_i == `MSG_REG_LINK && wb_sel_i[0] && wb_dat_i[0]) next_link_err = 1'b0;
    // RULE14: off-line time in ms, byte lanes honoured
    if (wr && wb_adr_i == `MSG_REG_TIMER) begin
      if (wb_sel_i[0]) next_tmr[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_tmr[15:8] = wb_dat_i[15:8];
    end
    if (ds_wait) begin
      if (ds_ans_i) next_ds_wait = 1'b0;
      else if (ms_cnt == MS_LAST) begin
        next_ms_cnt = 18'h00000;
        next_ms_left = ms_left - 16'h0001;
      end else next_ms_cnt = ms_cnt + 18'h00001;
    end
    // RULE12: timeout leaves the request unanswered
    if (timeout) begin
      next_ds_wait = 1'b0;
      next_r_sup = 1'b1;
      next_link_err = 1'b1;
    end
    if (accept) begin
      next_rdy = 1'b1;
      next_r_fn = f_fn;
      next_r_exc = exc;
      next_r_bc = f_adr == 8'h00;
      next_r_sup = f_adr == 8'h00;
      // RULE10: pass-through starts the downstream wait
      if (exc == `MSG_EXC_NONE && f_fn == `MSG_FN_PASS) begin
        next_ds_req = 1'b1;
        next_ds_wait = 1'b1;
        next_ms_cnt = 18'h00000;
        next_ms_left = tmr;
      end
    end
    // RULE3: pending work dropped on switch change
    if (cfg_chg) next_ds_wait = 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdy <= 1'b0;
      link_err <= 1'b0;
      ds_wait <= 1'b0;
      r_sup <= 1'b0;
      r_bc <= 1'b0;
      r_fn <= 8'h00;
      r_exc <= 8'h00;
      // RULE11: default off-line time
      tmr <= `MSG_OFFLINE_MS;
      ms_left <= 16'h0000;
      ms_cnt <= 18'h00000;
      ds_req_o <= 1'b0;
    end else begin
      rdy <= next_rdy;
      link_err <= next_link_err;
      ds_wait <= next_ds_wait;
      r_sup <= next_r_sup;
      r_bc <= next_r_bc;
      r_fn <= next_r_fn;
      r_exc <= next_r_exc;
      tmr <= next_tmr;
      ms_left <= next_ms_left;
      ms_cnt <= next_ms_cnt;
      ds_req_o <= next_ds_req;
    end
  end

  // ----------------------------------------
  // transmitter and wishbone slave
  // ----------------------------------------
  logic [10:0] tsh, next_tsh;
  logic [3:0] tn, next_tn;
  msg_cnt_t tc, next_tc;
  logic next_ack;
  logic [31:0] next_rd;
  always_comb begin
    next_tsh = tsh;
    next_tn = tn;
    next_tc = tc;
    if (tn != 4'h0) begin
      if (tc >= bit_len - 16'h0001) begin
        next_tc = 16'h0000;
        next_tsh = {1'b1, tsh[10:1]};
        next_tn = tn - 4'h1;
      end else next_tc = tc + 16'h0001;
    end else if (wr && wb_adr_i == `MSG_REG_TX && wb_sel_i[0]) begin
      // RULE17 / RULE18: start, data lsb first, parity or stop, stop
      next_tc = 16'h0000;
      next_tn = ascii ? 4'ha : 4'hb;
      next_tsh = ascii ? {2'b11, nopar | ^wb_dat_i[6:0], wb_dat_i[6:0], 1'b0}
                       : {1'b1, nopar | ^wb_dat_i[7:0], wb_dat_i[7:0], 1'b0};
    end
    if (cfg_chg) begin
      next_tn = 4'h0;
      next_tsh = 11'h7ff;
    end
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    case (wb_adr_i)
      `MSG_REG_STATUS: next_rd = {8'h00, r_exc, r_fn, 2'b00, enabled, r_bc, r_sup, ds_wait, link_err, rdy};
      `MSG_REG_TIMER: next_rd = {16'h0000, tmr};
      `MSG_REG_TX: next_rd = {31'h00000000, tn != 4'h0};
      `MSG_REG_LINK: next_rd = {31'h00000000, link_err};
      default: next_rd = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tsh <= 11'h7ff;
      tn <= 4'h0;
      tc <= 16'h0000;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      line_txd_o <= 1'b1;
      line_drive_en_o <= 1'b0;
    end else begin
      tsh <= next_tsh;
      tn <= next_tn;
      tc <= next_tc;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rd;
      line_txd_o <= next_tsh[0];
      line_drive_en_o <= next_tn != 4'h0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_ds_start;
    accept && exc == `MSG_EXC_NONE && f_fn == `MSG_FN_PASS && !cfg_chg;
  endsequence
  sequence s_ds_pulse;
    ds_req_o && ds_wait ##1 !ds_req_o;
  endsequence
  node_match_a: assert property (accept |-> (f_adr == node_address_switches_i || f_adr == 8'h00) || cfg_chg) else $error("address mismatch accepted"); // RULE1
  reserved_addr_a: assert property (enabled |-> node inside {[8'h01:8'hf7]}) else $error("reserved address enabled"); // RULE2
  switch_abort_a: assert property (cfg_chg |=> rs == R_IDLE && !f_act && !ds_wait) else $error("no abort on switch change"); // RULE3
  parity_fail_a: assert property (char_v && char_err && !ascii && f_act && !cfg_chg |=> f_bad || !f_act) else $error("bad char kept"); // RULE5
  func_filter_a: assert property (accept && !link_err && !sup |=> r_exc == `MSG_EXC_FUNC) else $error("unsupported function passed"); // RULE9
  pass_req_a: assert property (s_ds_start |=> s_ds_pulse) else $error("pass-through request missing"); // RULE10
  timer_default_a: assert property ($fell(sys_rst_i) |-> tmr == `MSG_OFFLINE_MS) else $error("timer default wrong"); // RULE11
  offline_a: assert property (timeout |=> r_sup && link_err && !ds_wait) else $error("timeout not handled"); // RULE12
  link_exc_a: assert property (accept && link_err |=> r_exc == `MSG_EXC_LINK && !ds_req_o) else $error("link error answer wrong"); // RULE13
  rtu_idle_a: assert property (f_act && !ascii && gb == T35 && !cfg_chg |=> !f_act) else $error("frame not closed on idle"); // RULE19
endmodule
`default_nettype wire

//--- rtl/msg_pkg.sv
// types of the serial slave front end
// assumes msg_cfg.svh for all numbers
package msg_pkg;
  typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} msg_rx_e;
  typedef logic [15:0] msg_cnt_t;
endpackage

//--- tb/msg_master_model.sv
// bus master model: drives the serial receive line of the front end
// assumes rtu or ascii framing, even parity and one fixed bit length in clock cycles
`include "msg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_master_model #(
  parameter int BIT_CYC = 1736
) (
  input wire logic clk_i,
  output logic line_o
);
  // idle line rests high, as the pull-up level of the pair
  initial begin
    line_o = 1'b1;
  end

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ `MSG_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  task automatic send_char(input logic [7:0] d, input logic bad_par, input int nd = 8);
    logic [10:0] fr;
    fr = (nd == 7) ? {2'b11, (^d[6:0]) ^ bad_par, d[6:0], 1'b0} : {1'b1, (^d) ^ bad_par, d, 1'b0};
    for (int i = 0; i < nd + 3; i++) begin
      @(posedge clk_i);
      line_o <= fr[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask

  task automatic send_frame(input logic [7:0] a, input logic [7:0] fn, input logic bad_par);
    logic [15:0] c;
    c = crc_upd(crc_upd(`MSG_CRC_INIT, a), fn);
    send_char(a, 1'b0);
    send_char(fn, bad_par);
    send_char(c[7:0], 1'b0);
    send_char(c[15:8], 1'b0);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// testbench of the serial slave front end: wishbone tasks and directed tests
// assumes the master model on the receive line and a 200 MHz clock
`include "msg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int CPM = 20;
  // a slow nominal clock keeps serial frames short in simulation
  localparam int SIM_HZ = 4000000;
  localparam int BIT115 = SIM_HZ / `MSG_BAUD_3;
  localparam int LIMIT = 60000;
  localparam int BLEN [4] = '{SIM_HZ / `MSG_BAUD_0, SIM_HZ / `MSG_BAUD_1,
                              SIM_HZ / `MSG_BAUD_2, SIM_HZ / `MSG_BAUD_3};
  localparam logic [7:0] ASC [9] = '{8'h3a, 8'h30, 8'h41, 8'h30, 8'h38, 8'h45, 8'h45, 8'h0d, 8'h0a};
  localparam logic [15:0] ADR_TAB [6] = '{16'h0000, 16'h0101, 16'hf701, 16'hf800, 16'h1f01, 16'hff00};
  logic clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, node_address_switches_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic parity_select_switch_i, framing_mode_switch_i, baud_select_high_switch_i, baud_select_low_switch_i;
  logic line_rxd_i, line_txd_o, line_drive_en_o, ds_req_o;
  logic ds_ans_i = 1'b0;
  logic ans_en = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc_n = 0;
  int ds_seen = 0;

  msg_front_end #(.CLK_HZ(SIM_HZ), .CYC_PER_MS(CPM)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .node_address_switches_i(node_address_switches_i),
    .parity_select_switch_i(parity_select_switch_i), .framing_mode_switch_i(framing_mode_switch_i),
    .baud_select_high_switch_i(baud_select_high_switch_i), .baud_select_low_switch_i(baud_select_low_switch_i),
    .line_rxd_i(line_rxd_i), .line_txd_o(line_txd_o), .line_drive_en_o(line_drive_en_o),
    .ds_req_o(ds_req_o), .ds_ans_i(ds_ans_i));
  msg_master_model #(.BIT_CYC(BIT115)) mm (.clk_i(clk_i), .line_o(line_rxd_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // downstream stand-in answers one cycle after a request when enabled
  always @(posedge clk_i) begin
    ds_ans_i <= ans_en & (ds_req_o === 1'b1);
    if (ds_req_o === 1'b1) ds_seen++;
    cyc_n++;
    if (cyc_n == LIMIT) begin
      n_fail++;
      stop_test();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until ack is sampled high, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk("wb ack latency", 32'h2, 32'(n));
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // frame to node 0a, then the 3.5 char silence that closes it
  task automatic run_frame(input logic [7:0] fn, input logic bad, input logic ans);
    wb(1'b1, `MSG_REG_STATUS, 4'h1, 32'h1);
    ans_en <= ans;
    mm.send_frame(8'h0a, fn, bad);
    repeat (39 * BIT115 + 300) @(posedge clk_i);
    wb(1'b0, `MSG_REG_STATUS, 4'h1, 32'h0);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int n;
    logic [10:0] efr;
    sys_rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    node_address_switches_i = 8'h0a;
    {parity_select_switch_i, framing_mode_switch_i} = 2'b00;
    {baud_select_high_switch_i, baud_select_low_switch_i} = 2'b11;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wb(1'b0, `MSG_REG_TIMER, 4'h3, 32'h0);
    chk("timer reset", {16'h0, `MSG_OFFLINE_MS}, rd);
    wb(1'b0, 8'h10, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    foreach (ADR_TAB[i]) begin
      @(posedge clk_i);
      node_address_switches_i <= ADR_TAB[i][15:8];
      repeat (4) @(posedge clk_i);
      wb(1'b0, `MSG_REG_STATUS, 4'h1, 32'h0);
      chk("enabled", ADR_TAB[i][0], rd[5]);
    end
    node_address_switches_i <= 8'h0a;
    // only lane 0 written: timer becomes 2 ms
    wb(1'b1, `MSG_REG_TIMER, 4'h1, 32'h0000_0302);
    wb(1'b0, `MSG_REG_TIMER, 4'h3, 32'h0);
    chk("timer rw", 32'h2, rd);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {baud_select_high_switch_i, baud_select_low_switch_i} <= 2'(i);
      repeat (4) @(posedge clk_i);
      wb(1'b1, `MSG_REG_TX, 4'h1, 32'h1);
      n = 0;
      while (line_txd_o !== 1'b0 && n < 100) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      while (line_txd_o === 1'b0 && n < 30000) begin
        @(posedge clk_i);
        n++;
      end
      chk("bit length", 32'(BLEN[i]), 32'(n));
      parity_select_switch_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("abort drive", 32'h0, line_drive_en_o);
      wb(1'b0, `MSG_REG_TX, 4'h1, 32'h0);
      chk("tx busy", 32'h0, rd[0]);
      parity_select_switch_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    $display("baud done");
    wb(1'b1, `MSG_REG_TX, 4'h1, 32'h57);
    efr = {1'b1, ^8'h57, 8'h57, 1'b0};
    n = 0;
    while (line_txd_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BIT115 / 2) @(posedge clk_i);
    for (int b = 0; b < 11; b++) begin
      chk("tx bit", efr[b], line_txd_o);
      chk("tx drive", 32'h1, line_drive_en_o);
      repeat (BIT115) @(posedge clk_i);
    end
    $display("tx done");
    // the aborts above only return the receiver to R_IDLE and leave the idle count gb at T35
    repeat (40 * BIT115) @(posedge clk_i);
    run_frame(8'h41, 1'b0, 1'b1);
    chk("ready", 32'h1, rd[0]);
    chk("function", 32'h41, rd[15:8]);
    chk("ds request", 32'h1, 32'(ds_seen));
    chk("link ok", 32'h0, rd[1]);
    run_frame(8'h41, 1'b0, 1'b0);
    chk("suppress", 32'h1, rd[3]);
    chk("link error", 32'h1, rd[1]);
    run_frame(8'h07, 1'b0, 1'b0);
    chk("exc link", `MSG_EXC_LINK, rd[23:16]);
    chk("no request", 32'h2, 32'(ds_seen));
    wb(1'b1, `MSG_REG_LINK, 4'h1, 32'h1);
    wb(1'b0, `MSG_REG_LINK, 4'h1, 32'h0);
    chk("link clear", 32'h0, rd[0]);
    run_frame(8'h07, 1'b1, 1'b0);
    chk("parity drop", 32'h0, rd[0]);
    run_frame(8'h07, 1'b0, 1'b0);
    chk("ready", 32'h1, rd[0]);
    chk("exc func", `MSG_EXC_FUNC, rd[23:16]);
    chk("function", 32'h07, rd[15:8]);
    // ascii frame to node 0a, function 08, lrc ee
    framing_mode_switch_i <= 1'b1;
    wb(1'b1, `MSG_REG_STATUS, 4'h1, 32'h1);
    foreach (ASC[i]) mm.send_char(ASC[i], 1'b0, 7);
    repeat (BIT115) @(posedge clk_i);
    wb(1'b0, `MSG_REG_STATUS, 4'h1, 32'h0);
    chk("ascii ready", 32'h1, rd[0]);
    chk("ascii function", 32'h08, rd[15:8]);
    chk("ascii exc", `MSG_EXC_NONE, rd[23:16]);
    $display("frames done");
    stop_test();
  end
endmodule
`default_nettype wire
